//--- ecssdc_pkg.sv
// Constants shared by the event, sag/surge and pin configuration logic.
// Assumes a 20 MHz core clock and a 16-bit register port from the serial link decoder.
`default_nettype none

package ecssdc_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned REG_AW          = 16;
    localparam int unsigned REG_DW          = 16;
    localparam int unsigned NUM_EVENTS      = 10;
    localparam int unsigned NUM_PINS        = 4;
    localparam int unsigned FIELD_W         = 3;

    // Register offsets
    localparam logic [15:0] PIN_CFG_ADDR    = 16'h0046;
    localparam logic [15:0] EVT_TEST_ADDR   = 16'h0090;
    localparam logic [15:0] EVT_CLEAR_ADDR  = 16'h0092;

    // Event bits occupy 15 down to 6
    localparam int unsigned EVT_LSB         = 6;
    localparam int unsigned EVT_MSB         = 15;
    localparam int unsigned EVT_DIP_IDX     = 1;  // voltage_dip_event, bit 7
    localparam int unsigned EVT_SWELL_IDX   = 0;  // voltage_swell_event, bit 6
    localparam int unsigned NUM_CYCLE_EVTS  = 8;  // bits 15..8

    // Pin field positions and codes
    localparam int unsigned PIN_FIELD_LSB [NUM_PINS] = '{0, 3, 6, 9};
    localparam int unsigned PIN_CFG_USED_W  = 12;
    localparam logic [2:0] CODE_STD_OUT     = 3'h5;
    localparam logic [2:0] CODE_CRIT_OUT    = 3'h4;
    localparam logic [2:0] CODE_SPECIAL     = 3'h3;
    localparam logic [2:0] CODE_INPUT       = 3'h2;
    localparam logic [15:0] PIN_CFG_RESET   = 16'h0492;
    localparam logic [15:0] EVT_RESET       = 16'h0000;

    // Cycles after reset release before the bus mode strap is caught
    localparam logic [1:0] STRAP_WAIT_CYCLES = 2'h3;

    typedef enum {
        ECSSDC_FN_INPUT,
        ECSSDC_FN_STD,
        ECSSDC_FN_CRIT,
        ECSSDC_FN_ADDR,
        ECSSDC_FN_TEMP
    } ecssdc_pin_fn_e;
endpackage

`default_nettype wire

//--- ecssdc_sag_if.sv
// Interface between the event core and the trailing mean square detector.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
`default_nettype none

interface ecssdc_sag_if;
    logic               sample_valid;
    logic signed [15:0] sample;
    logic [15:0]        dip_limit;
    logic [15:0]        swell_limit;
    logic               dip_hit;
    logic               swell_hit;
    logic [31:0]        mean_sq;

    modport det (
        input  sample_valid,
        input  sample,
        input  dip_limit,
        input  swell_limit,
        output dip_hit,
        output swell_hit,
        output mean_sq
    );
    modport ctl (
        output sample_valid,
        output sample,
        output dip_limit,
        output swell_limit,
        input  dip_hit,
        input  swell_hit,
        input  mean_sq
    );
endinterface

`default_nettype wire

//--- ecssdc_sag_detect.sv
// Trailing mean square of voltage over half a line period, judged at every data-ready after the first 2**LOG2_N.
// Assumes the half period holds 2**LOG2_N samples; sample_valid is the data-ready strobe.
`timescale 1ns/10ps
`default_nettype none

module ecssdc_sag_detect #(
    parameter int unsigned LOG2_N = 5
) (
    input  wire logic     clk,
    input  wire logic     rst,
    ecssdc_sag_if.det     sif
);
    localparam int unsigned N     = 1 << LOG2_N;
    localparam int unsigned SUM_W = 32 + LOG2_N;

    logic [31:0]       sq_mem [N];
    logic [LOG2_N-1:0] wr_ptr_q;
    logic [SUM_W-1:0]  sum_q;
    logic [SUM_W-1:0]  sum_d;
    logic [31:0]       sq_new;
    logic [31:0]       mean_d;
    logic              dip_q;
    logic              swell_q;
    logic [31:0]       mean_q;
    logic [N-1:0]      filled_q;

    // Widen before squaring, a 16-bit product would lose the top half
    assign sq_new = 32'(sif.sample) * 32'(sif.sample);
    assign sum_d  = sum_q + SUM_W'(sq_new) - (filled_q[N-1] ? SUM_W'(sq_mem[wr_ptr_q]) : '0);
    assign mean_d = 32'(sum_d >> LOG2_N);

    always_ff @(posedge clk) begin
        if (sif.sample_valid) begin
            sq_mem[wr_ptr_q] <= sq_new;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= '0;
            sum_q    <= '0;
            mean_q   <= '0;
        end else if (sif.sample_valid) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
            sum_q    <= sum_d;
            mean_q   <= mean_d;
        end
    end

    // Memory is not cleared; old squares leave the sum only once the window has filled
    always_ff @(posedge clk) begin
        if (rst) begin
            filled_q <= '0;
        end else if (sif.sample_valid) begin
            filled_q <= {filled_q[N-2:0], 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dip_q   <= 1'b0;
            swell_q <= 1'b0;
        end else begin
            dip_q   <= sif.sample_valid && filled_q[N-1] && (mean_d[31:16] < sif.dip_limit);
            swell_q <= sif.sample_valid && filled_q[N-1] && (mean_d[31:16] > sif.swell_limit);
        end
    end

    assign sif.dip_hit   = dip_q;
    assign sif.swell_hit = swell_q;
    assign sif.mean_sq   = mean_q;
endmodule

`default_nettype wire

//--- ecssdc_top.sv
// Event latching and clearing, sag/surge detection and configurable pin control.
// Assumes a register port driven by the serial link decoder and masks/limits held elsewhere.
//
// Notes on behaviour
// - Clear bit one clears matching event
// - Clearing test-raised event drops test bit
// - Clear bits return to zero automatically
// - Clear bits fifteen to six; low read zero
// - Slow events per cycle; sag/surge fast
// - Sag and surge use no hold count
// - Trailing half-period mean square of voltage
// - Compare mean square at each data-ready after first window
// - Masked sag/surge drive notification pin high
// - Sag/surge stay latched until host clears
// - Four pins, five possible functions
// - Notification pins follow class event masks
// - Pins reset to inputs, level mirrored
// - Strap low: pins zero, one address
// - Strap high: pins zero, one free
// - Temperature input passes thermistor reading
// - Pin two output: thermistor reads zero
// - Three-bit field per pin, upper zero
// - 101 standard, 100 critical, 010 input
// - Pin two 011 is temperature input
// - Pins zero, one 011 address input
// - Test bit raises; zero clears test only
// - Standard mask gates fault to pin
`timescale 1ns/10ps
`default_nettype none

module ecssdc_top #(
    parameter int unsigned LOG2_N = 5
) (
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port from the serial link
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    // Computation cycle events
    input  wire logic        comp_done,
    input  wire logic [7:0]  limit_breach,
    // Voltage samples and limits
    input  wire logic        data_ready,
    input  wire logic [15:0] voltage_sample,
    input  wire logic [15:0] dip_limit,
    input  wire logic [15:0] swell_limit,
    // Masks held in the mask registers
    input  wire logic [9:0]  std_mask,
    input  wire logic [9:0]  crit_mask,
    // Thermistor converter
    input  wire logic [15:0] therm_adc,
    input  wire logic        therm_valid,
    output logic      [15:0] thermistor_voltage,
    // Pins
    input  wire logic        bus_mode_pin,
    input  wire logic [3:0]  config_pin_i,
    output logic      [3:0]  config_pin_o,
    output logic      [3:0]  config_pin_oe,
    // State shown elsewhere
    output logic      [9:0]  event_flags,
    output logic      [3:0]  pin_level,
    output logic      [1:0]  device_addr,
    output logic             multi_device,
    output logic             std_notify,
    output logic             crit_notify
);
    localparam int unsigned NE = ecssdc_pkg::NUM_EVENTS;
    localparam int unsigned NP = ecssdc_pkg::NUM_PINS;

    // Field decode, used for every pin
    function automatic ecssdc_pkg::ecssdc_pin_fn_e ecssdc_decode(input logic [2:0] code,
                                                                 input int unsigned pin,
                                                                 input logic addr_free);
        ecssdc_pkg::ecssdc_pin_fn_e fn;
        fn = ecssdc_pkg::ECSSDC_FN_INPUT;
        if (code == ecssdc_pkg::CODE_STD_OUT) begin
            fn = ecssdc_pkg::ECSSDC_FN_STD;
        end else if (code == ecssdc_pkg::CODE_CRIT_OUT) begin
            fn = ecssdc_pkg::ECSSDC_FN_CRIT;
        end else if (code == ecssdc_pkg::CODE_SPECIAL) begin
            if (pin == 2) begin
                fn = ecssdc_pkg::ECSSDC_FN_TEMP;
            end else if (pin < 2 && addr_free) begin
                fn = ecssdc_pkg::ECSSDC_FN_ADDR;
            end
        end
        return fn;
    endfunction

    // Pin and strap synchronisers
    logic [NP:0] sync1_q;
    logic [NP:0] sync2_q;
    logic [NP:0] sync3_q;
    logic [NP:0] level_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            level_q <= '0;
        end else begin
            sync1_q <= {bus_mode_pin, config_pin_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i <= NP; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    level_q[i] <= sync3_q[i];
                end
            end
        end
    end

    // Strap caught after the synchroniser has refilled
    logic [1:0] strap_cnt_q;
    logic       strap_done_q;
    logic       multi_q;
    logic       strap_level;

    // Level the filter settles on at this edge; level_q itself is one cycle late
    assign strap_level = (sync2_q[NP] == sync3_q[NP]) ? sync3_q[NP] : level_q[NP];

    always_ff @(posedge clk) begin
        if (rst) begin
            strap_cnt_q  <= '0;
            strap_done_q <= 1'b0;
            multi_q      <= 1'b0;
        end else if (!strap_done_q) begin
            if (strap_cnt_q == ecssdc_pkg::STRAP_WAIT_CYCLES) begin
                strap_done_q <= 1'b1;
                multi_q      <= ~strap_level;
            end else begin
                strap_cnt_q <= strap_cnt_q + 1'b1;
            end
        end
    end

    // Register file
    logic [15:0] pin_cfg_q;
    logic [NE-1:0] test_q;
    logic [NE-1:0] clear_q;
    logic [NE-1:0] real_q;
    logic          wr_cfg;
    logic          wr_test;
    logic          wr_clear;

    assign wr_cfg   = reg_wr && (reg_addr == ecssdc_pkg::PIN_CFG_ADDR);
    assign wr_test  = reg_wr && (reg_addr == ecssdc_pkg::EVT_TEST_ADDR);
    assign wr_clear = reg_wr && (reg_addr == ecssdc_pkg::EVT_CLEAR_ADDR);

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_cfg_q <= ecssdc_pkg::PIN_CFG_RESET;
        end else if (wr_cfg) begin
            pin_cfg_q <= {4'h0, reg_wdata[ecssdc_pkg::PIN_CFG_USED_W-1:0]};
        end
    end

    // Sag/surge detector
    ecssdc_sag_if sif ();
    assign sif.sample_valid = data_ready;
    assign sif.sample       = voltage_sample;
    assign sif.dip_limit    = dip_limit;
    assign sif.swell_limit  = swell_limit;

    ecssdc_sag_detect #(
        .LOG2_N (LOG2_N)
    ) u_sag (
        .clk (clk),
        .rst (rst),
        .sif (sif)
    );

    // Raise sources for this cycle
    logic [NE-1:0] real_set;
    // slow events sampled per computation cycle, fast ones per data-ready
    assign real_set = {(comp_done ? limit_breach : 8'h00), sif.dip_hit, sif.swell_hit};

    always_ff @(posedge clk) begin
        if (rst) begin
            real_q <= '0;
        end else begin
            real_q <= real_set | (real_q & ~clear_q);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            test_q <= '0;
        end else if (wr_test) begin
            test_q <= reg_wdata[ecssdc_pkg::EVT_MSB:ecssdc_pkg::EVT_LSB];
        end else begin
            test_q <= test_q & ~clear_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clear_q <= '0;
        end else begin
            for (int i = 0; i < NE; i++) begin
                if (wr_clear && reg_wdata[ecssdc_pkg::EVT_LSB+i]) begin
                    clear_q[i] <= 1'b1;
                end else if (!real_q[i] && !test_q[i]) begin
                    clear_q[i] <= 1'b0;
                end
            end
        end
    end

    // Flag follows both sources
    logic [NE-1:0] flag;
    assign flag        = real_q | test_q;
    assign event_flags = flag;

    logic std_q;
    logic crit_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            std_q  <= 1'b0;
            crit_q <= 1'b0;
        end else begin
            std_q  <= |(flag & std_mask);
            crit_q <= |(flag & crit_mask);
        end
    end
    assign std_notify  = std_q;
    assign crit_notify = crit_q;

    // Per-pin function and drive
    logic [NP-1:0] pin_o_q;
    logic [NP-1:0] pin_oe_q;
    logic [NP-1:0] is_temp;
    logic [NP-1:0] is_out;
    logic [NP-1:0] is_addr;

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_pin
            ecssdc_pkg::ecssdc_pin_fn_e fn;
            logic                       disabled;
            assign disabled = (gp < 2) && multi_q;
            assign fn = ecssdc_decode(pin_cfg_q[ecssdc_pkg::PIN_FIELD_LSB[gp] +: ecssdc_pkg::FIELD_W],
                                      gp, !multi_q);
            assign is_temp[gp] = (fn == ecssdc_pkg::ECSSDC_FN_TEMP);
            assign is_addr[gp] = disabled || (fn == ecssdc_pkg::ECSSDC_FN_ADDR);
            assign is_out[gp]  = !disabled && ((fn == ecssdc_pkg::ECSSDC_FN_STD) ||
                                               (fn == ecssdc_pkg::ECSSDC_FN_CRIT));

            always_ff @(posedge clk) begin
                if (rst) begin
                    pin_o_q[gp]  <= 1'b0;
                    pin_oe_q[gp] <= 1'b0;
                end else begin
                    pin_oe_q[gp] <= is_out[gp];
                    unique case (fn)
                        ecssdc_pkg::ECSSDC_FN_STD:  pin_o_q[gp] <= !disabled && std_q;
                        ecssdc_pkg::ECSSDC_FN_CRIT: pin_o_q[gp] <= !disabled && crit_q;
                        ecssdc_pkg::ECSSDC_FN_INPUT,
                        ecssdc_pkg::ECSSDC_FN_ADDR,
                        ecssdc_pkg::ECSSDC_FN_TEMP: pin_o_q[gp] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    assign config_pin_o  = pin_o_q;
    assign config_pin_oe = pin_oe_q;

    assign pin_level    = level_q[NP-1:0];
    assign multi_device = multi_q;

    logic [1:0] addr_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q <= '0;
        end else begin
            addr_q <= {is_addr[1] & level_q[1], is_addr[0] & level_q[0]};
        end
    end
    assign device_addr = addr_q;

    logic [15:0] therm_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            therm_q <= '0;
        end else if (!is_temp[2]) begin
            therm_q <= '0;
        end else if (therm_valid) begin
            therm_q <= therm_adc;
        end
    end
    assign thermistor_voltage = therm_q;

    // Read port, one cycle latency
    logic [15:0] rdata_q;
    logic        rvalid_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    ecssdc_pkg::PIN_CFG_ADDR:   rdata_q <= pin_cfg_q;
                    ecssdc_pkg::EVT_TEST_ADDR:  rdata_q <= {test_q, 6'h00};
                    ecssdc_pkg::EVT_CLEAR_ADDR: rdata_q <= {clear_q, 6'h00};
                    default:                    rdata_q <= 16'h0000;
                endcase
            end
        end
    end
    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;
endmodule

`default_nettype wire

//--- ecssdc_pin_far.sv
// Far side of the four configurable pins: external logic with pull-downs.
// Assumes the device drive wins where both sides would drive a pin.
`timescale 1ns/10ps
`default_nettype none

module ecssdc_pin_far (
    input  wire logic [3:0] ext_drive,
    input  wire logic [3:0] ext_en,
    input  wire logic [3:0] dev_o,
    input  wire logic [3:0] dev_oe,
    output logic      [3:0] pin_wire
);
    // Undriven pins fall to the pull-down, never keep a stale level
    assign pin_wire = (dev_oe & dev_o) | (~dev_oe & ext_en & ext_drive);
endmodule

`default_nettype wire

//--- ecssdc_top_asserts.sv
// Checker on the top ports: register reads, event latching, notification and pins.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module ecssdc_top_asserts #(
    parameter int unsigned LOG2_N = 5
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        comp_done,
    input wire logic [7:0]  limit_breach,
    input wire logic [9:0]  std_mask,
    input wire logic [9:0]  crit_mask,
    input wire logic [15:0] thermistor_voltage,
    input wire logic [3:0]  config_pin_o,
    input wire logic [3:0]  config_pin_oe,
    input wire logic [9:0]  event_flags,
    input wire logic        multi_device,
    input wire logic        std_notify,
    input wire logic        crit_notify
);
    logic [2:0] p0_q;
    logic [2:0] p2_q;
    logic [2:0] p3_q;

    // Shadow of pin codes, since the checker cannot see the register
    always_ff @(posedge clk) begin
        if (rst) begin
            p0_q <= 3'h2;
            p2_q <= 3'h2;
            p3_q <= 3'h2;
        end else if (reg_wr && reg_addr == ecssdc_pkg::PIN_CFG_ADDR) begin
            p0_q <= reg_wdata[2:0];
            p2_q <= reg_wdata[8:6];
            p3_q <= reg_wdata[11:9];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    clear_low_zero_a: assert property (
        reg_rvalid && $past(reg_addr) == ecssdc_pkg::EVT_CLEAR_ADDR |-> reg_rdata[5:0] == 6'h0)
        else $error("clear register low bits not zero");
    cfg_upper_zero_a: assert property (
        reg_rvalid && $past(reg_addr) == ecssdc_pkg::PIN_CFG_ADDR |-> reg_rdata[15:12] == 4'h0)
        else $error("pin config upper bits not zero");
    event_set_a: assert property (
        comp_done && limit_breach[7] |=> event_flags[9])
        else $error("breach not latched");
    flag_hold_a: assert property (
        !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2) |=> (event_flags & $past(event_flags)) == $past(event_flags))
        else $error("latched event dropped without a write");
    std_follow_a: assert property (
        1'b1 |=> std_notify == |($past(event_flags) & $past(std_mask)))
        else $error("standard notify does not follow masked events");
    crit_follow_a: assert property (
        1'b1 |=> crit_notify == |($past(event_flags) & $past(crit_mask)))
        else $error("critical notify does not follow masked events");
    addr_mode_a: assert property (
        multi_device |-> config_pin_oe[1:0] == 2'h0)
        else $error("address pins driven in multi-device mode");
    therm_zero_a: assert property (
        p2_q != 3'h3 && $past(p2_q) != 3'h3 |-> thermistor_voltage == 16'h0)
        else $error("thermistor value not zero");
    unused_code_a: assert property (
        !(p3_q inside {3'h4, 3'h5}) && !($past(p3_q) inside {3'h4, 3'h5}) |-> !config_pin_oe[3])
        else $error("pin three driven without output code");
    pin_std_a: assert property (
        p0_q == 3'h5 && $past(p0_q) == 3'h5 && !multi_device
        |-> config_pin_oe[0] && config_pin_o[0] == $past(std_notify))
        else $error("standard output pin wrong");

    cover property (event_flags[0]);
    cover property (event_flags[1] && crit_notify);
    cover property ($rose(std_notify));
    cover property (reg_rvalid && multi_device);
endmodule

bind ecssdc_top ecssdc_top_asserts #(.LOG2_N(LOG2_N)) u_chk (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .reg_rvalid, .comp_done, .limit_breach,
    .std_mask, .crit_mask, .thermistor_voltage, .config_pin_o, .config_pin_oe, .event_flags,
    .multi_device, .std_notify, .crit_notify
);

`default_nettype wire

//--- testbench.sv
// Self-checking bench: register port tasks, events, sag/surge, pins and strap.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam logic [15:0] CFG = ecssdc_pkg::PIN_CFG_ADDR;
    localparam logic [15:0] TST = ecssdc_pkg::EVT_TEST_ADDR;
    localparam logic [15:0] CLR = ecssdc_pkg::EVT_CLEAR_ADDR;

    logic        clk, rst, reg_wr, reg_rd, comp_done, data_ready, therm_valid, bus_mode_pin;
    logic [15:0] reg_addr, reg_wdata, voltage_sample, dip_limit, swell_limit, therm_adc;
    logic [15:0] reg_rdata, thermistor_voltage;
    logic [7:0]  limit_breach;
    logic [9:0]  std_mask, crit_mask, event_flags;
    logic [3:0]  config_pin_i, config_pin_o, config_pin_oe, pin_level, ext_drive;
    logic [1:0]  device_addr;
    logic        reg_rvalid, multi_device, std_notify, crit_notify;
    int          num_errors, num_checks;

    // Short window keeps the sag/surge tests brief
    ecssdc_top #(.LOG2_N(2)) i_dut (
        .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .comp_done,
        .limit_breach, .data_ready, .voltage_sample, .dip_limit, .swell_limit, .std_mask, .crit_mask,
        .therm_adc, .therm_valid, .thermistor_voltage, .bus_mode_pin, .config_pin_i, .config_pin_o,
        .config_pin_oe, .event_flags, .pin_level, .device_addr, .multi_device, .std_notify, .crit_notify
    );
    ecssdc_pin_far i_far (.ext_drive, .ext_en(4'hf), .dev_o(config_pin_o), .dev_oe(config_pin_oe),
        .pin_wire(config_pin_i));

    always #25 clk = ~clk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rvalid, 16'h1);
        chk(reg_rdata, e);
    endtask
    task automatic ev(input logic [7:0] b);
        @(posedge clk);
        comp_done <= 1'b1;
        limit_breach <= b;
        @(posedge clk);
        comp_done <= 1'b0;
        limit_breach <= 8'h0;
    endtask
    task automatic smp(input logic [15:0] v, input int n);
        repeat (n) begin
            @(posedge clk);
            data_ready <= 1'b1;
            voltage_sample <= v;
            @(posedge clk);
            data_ready <= 1'b0;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        {clk, reg_wr, reg_rd, comp_done, data_ready, therm_valid} = 6'h0;
        {reg_addr, reg_wdata, voltage_sample, therm_adc, dip_limit, limit_breach} = '0;
        rst = 1'b1;
        bus_mode_pin = 1'b1;
        swell_limit = 16'hffff;
        std_mask = 10'h200;
        crit_mask = 10'h002;
        ext_drive = 4'ha;
        num_errors = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(8);
        rdchk(CFG, 16'h0492);
        chk(config_pin_oe, 16'h0);
        chk(pin_level, 16'h000a);
        chk(multi_device, 16'h0);
        rdchk(CLR, 16'h0);
        wr(CFG, 16'hffff);
        rdchk(CFG, 16'h0fff);
        wr(CFG, 16'h06e5);
        tick(3);
        chk(config_pin_oe, 16'h3);
        for (int k = 0; k < 8; k++) begin
            ev(8'h01 << k);
            tick(2);
            chk(event_flags, 10'h004 << k);
            wr(CLR, 16'h0100 << k);
            tick(3);
            chk(event_flags, 16'h0);
        end
        ev(8'h80);
        tick(3);
        chk(config_pin_o[0], 16'h1);
        chk(crit_notify, 16'h0);
        wr(TST, 16'h0);
        tick(3);
        chk(event_flags, 16'h0200);
        wr(CLR, 16'h8000);
        tick(4);
        chk(config_pin_o[0], 16'h0);
        rdchk(CLR, 16'h0);
        wr(TST, 16'h1000);
        tick(3);
        chk(event_flags, 16'h0040);
        chk(std_notify, 16'h0);
        wr(TST, 16'h0);
        tick(3);
        chk(event_flags, 16'h0);
        wr(TST, 16'h1000);
        wr(CLR, 16'h1000);
        tick(4);
        chk(event_flags, 16'h0);
        rdchk(TST, 16'h0);
        rdchk(CLR, 16'h0);
        @(posedge clk) swell_limit <= 16'h3fff;
        smp(16'h7fff, 4);
        tick(3);
        chk(event_flags, 16'h0);
        @(posedge clk) swell_limit <= 16'h3ffe;
        smp(16'h7fff, 1);
        tick(3);
        chk(event_flags, 16'h0001);
        @(posedge clk) dip_limit <= 16'h0001;
        smp(16'h0, 4);
        tick(4);
        chk(event_flags, 16'h0003);
        chk(config_pin_o[1], 16'h1);
        @(posedge clk) dip_limit <= 16'h0;
        wr(CLR, 16'h00c0);
        tick(3);
        chk(event_flags, 16'h0);
        @(posedge clk);
        therm_valid <= 1'b1;
        therm_adc <= 16'h1234;
        @(posedge clk) therm_valid <= 1'b0;
        tick(2);
        chk(thermistor_voltage, 16'h1234);
        wr(CFG, 16'h0765);
        tick(3);
        chk(thermistor_voltage, 16'h0);
        chk(config_pin_oe, 16'h7);
        @(posedge clk);
        rst <= 1'b1;
        bus_mode_pin <= 1'b0;
        ext_drive <= 4'h2;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(10);
        chk(multi_device, 16'h1);
        chk(device_addr, 16'h2);
        wr(CFG, 16'h0005);
        tick(3);
        chk(config_pin_oe, 16'h0);
        finish_test();
    end

    // Whole run takes under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule

`default_nettype wire
